/* src/remote_front_pkg.sv */
// Purpose: shared constants and types for the remote-control front end
// Assumes: 250 MHz core clock
// Notes: framing fields use small codes
package remote_front_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLOCK_HZ = 250_000_000;
    localparam int unsigned CHAR_GAP_US = 1000;           // gap between bytes, lower end
    localparam int unsigned CHAR_GAP_CYCLES = (CLOCK_HZ / 1_000_000) * CHAR_GAP_US;
    localparam int unsigned MAX_BAUD = 19200;
    localparam int unsigned MIN_BAUD = 600;
    // ************************************************************
    // addresses and characters
    // ************************************************************
    localparam logic [4:0] BUS_ADDR_PRESET = 5'h09;
    localparam logic [4:0] BUS_ADDR_MAX = 5'h1E;
    localparam logic [7:0] CH_STX = 8'h02;
    localparam logic [7:0] CH_ETX = 8'h03;
    localparam logic [7:0] CH_EOT = 8'h04;
    localparam logic [7:0] CH_ENQ = 8'h05;
    localparam logic [7:0] CH_P = 8'h70;
    localparam logic [7:0] CH_O = 8'h6F;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_EVEN = 2'h1,
        PAR_ODD = 2'h2
    } parity_t;
    typedef enum logic [1:0] {
        IF_PARALLEL = 2'h0,
        IF_RS232 = 2'h1,
        IF_RS485 = 2'h2
    } iface_t;
    typedef struct packed {
        logic [15:0] baud_div;   // core cycles per bit
        logic eight_bits;
        logic two_stops;
        parity_t parity;
        logic full_duplex;
        logic char_delay;
        logic block_check;
        logic [3:0] group_addr;
        logic [3:0] user_addr;
    } serial_cfg_t;
    typedef enum logic [2:0] {
        P_IDLE = 3'h0,
        P_G1 = 3'h1,
        P_G2 = 3'h3,
        P_U1 = 3'h2,
        P_U2 = 3'h6,
        P_P = 3'h7,
        P_O = 3'h5
    } poll_t;
    typedef enum logic [2:0] {
        T_IDLE = 3'h0,
        T_DATA = 3'h1,
        T_BCC = 3'h3,
        T_EOT = 3'h2,
        T_GAP = 3'h6
    } tx_t;
    // hex digit as ascii, lower case
    function automatic logic [7:0] hex_char(input logic [3:0] d);
        hex_char = (d < 4'hA) ? 8'(8'h30 + d) : 8'(8'h57 + d);
    endfunction : hex_char
endpackage : remote_front_pkg

/* src/byte_fifo.sv */
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: one pointer bit extra gives honest full and empty
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    // full when pointers differ only in the wrap bit
    assign in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o = mem[rd_ptr[AW-1:0]];
    // storage has no reset, the pointers guard it
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
        end
    end
endmodule : byte_fifo
`default_nettype wire

/* src/remote_front.sv */
// Purpose: remote/local control, interface selection, serial poll and framing
// Assumes: command parsing happens outside; this block sees decoded events
// Notes: serial rx/tx bytes are framed here, bit-level uart lives elsewhere
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - external control accepted only in remote state.
// - in remote, all panel keys except return-to-local key are ignored.
// - addressed command enters remote and relabels the return-to-local key.
// - return-to-local key or go-to-local command leaves remote state.
// - after local lockout, only go-to-local restores local operation.
// - parallel bus answered only when the parallel interface is selected.
// - parallel bus address settable 0 to 30, distinct per device.
// - parallel bus address presets to 9.
// - changed bus address takes effect at once.
// - query result goes to output buffer for a later bus read.
// - every panel setting is remote-settable except interface choice.
// - command language follows the 1990.0 programmable-instrument standard.
// - serial port works as RS232 or RS485 per interface setting.
// - serial protocol is multipoint 2.5 scheme with A3 or A4 blocks.
// - serial rate selectable in steps up to 19200 bit/s.
// - framing 7/8 data, 1/2 stop, even/odd/none parity, matching rate.
// - RS485 may be full or half duplex; not for RS232.
// - serial group address 0 to 15, one hex digit.
// - serial user address 0 to 15, one hex digit.
// - character delay option inserts about 1 ms gap between sent bytes.
// - block check option sends A4 blocks with check byte after end-of-text.
// - check byte is xor of bytes after start-of-text through end-of-text.
// - polled with nothing to send, answer EOT; otherwise start sending.
module remote_front #(
    parameter int unsigned GAP_CYCLES = remote_front_pkg::CHAR_GAP_CYCLES,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // interface selection, panel only
    input wire remote_front_pkg::iface_t iface_sel_i,
    // decoded bus events
    input wire logic addressed_cmd_i,
    input wire logic go_to_local_i,
    input wire logic local_lockout_i,
    input wire logic bus_cmd_from_parallel_i,
    // panel keys, raw pins
    input wire logic [7:0] panel_keys_i,
    input wire logic return_to_local_key_i,
    // bus address setting
    input wire logic [4:0] bus_addr_wdata_i,
    input wire logic bus_addr_we_i,
    input wire logic [4:0] bus_talk_addr_i,
    output logic bus_addr_match_o,
    output logic [4:0] bus_addr_o,
    // serial configuration
    input wire remote_front_pkg::serial_cfg_t serial_cfg_i,
    // received serial bytes
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_valid_i,
    // query answers
    input wire logic [7:0] answer_byte_i,
    input wire logic answer_valid_i,
    output logic answer_ready_o,
    // transmitted serial bytes
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    // parallel bus read
    input wire logic bus_read_i,
    output logic [7:0] bus_read_data_o,
    output logic bus_read_valid_o,
    // state
    output logic remote_o,
    output logic lockout_o,
    output logic key_shows_local_o,
    output logic [7:0] panel_keys_o,
    output logic cmd_accept_o,
    output logic rs485_o,
    output logic half_duplex_o,
    output logic [7:0] block_check_character_o
);
    import remote_front_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [8:0] key_meta;
    logic [8:0] key_sync;
    // panel key pins pass two flops before use
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            key_meta <= '0;
            key_sync <= '0;
        end else begin
            key_meta <= {return_to_local_key_i, panel_keys_i};
            key_sync <= key_meta;
        end
    end
    logic rtl_key_d;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rtl_key_d <= 1'b0;
        end else begin
            rtl_key_d <= key_sync[8];
        end
    end
    wire rtl_key_press = key_sync[8] && !rtl_key_d;

    // ************************************************************
    // remote / local state
    // ************************************************************
    logic remote;
    logic lockout;
    wire poll_hit;
    wire par_sel = (iface_sel_i == IF_PARALLEL);
    wire par_ok = !bus_cmd_from_parallel_i || par_sel;
    wire go_remote = addressed_cmd_i && par_ok;
    wire key_exit = rtl_key_press && !lockout;
    wire go_local = go_to_local_i || key_exit;
    wire next_remote = go_local ? 1'b0 : (go_remote || poll_hit) ? 1'b1 : remote;
    wire next_lockout = local_lockout_i || (lockout && !go_to_local_i);
    // leaving remote wins over entering it, so a stuck command can be undone; local lockout wins over go-to-local
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remote <= 1'b0;
            lockout <= 1'b0;
        end else begin
            remote <= next_remote;
            lockout <= next_lockout;
        end
    end
    assign remote_o = remote;
    assign lockout_o = lockout;
    assign key_shows_local_o = remote;
    assign panel_keys_o = remote ? 8'h00 : key_sync[7:0];
    assign cmd_accept_o = remote && par_ok;
    assign rs485_o = (iface_sel_i == IF_RS485);
    assign half_duplex_o = rs485_o && !serial_cfg_i.full_duplex;

    // ************************************************************
    // parallel bus address
    // ************************************************************
    logic [4:0] bus_addr;
    wire addr_ok = (bus_addr_wdata_i <= BUS_ADDR_MAX);
    // out-of-range writes are dropped
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_addr <= BUS_ADDR_PRESET;
        end else if (bus_addr_we_i && addr_ok) begin
            bus_addr <= bus_addr_wdata_i;
        end
    end
    assign bus_addr_o = bus_addr;
    assign bus_addr_match_o = par_sel && (bus_talk_addr_i == bus_addr);

    // ************************************************************
    // output buffer
    // ************************************************************
    wire [7:0] buf_data;
    wire buf_valid;
    wire buf_pop;
    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) out_buffer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_data_i(answer_byte_i),
        .in_valid_i(answer_valid_i),
        .in_ready_o(answer_ready_o),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop)
    );
    // parallel read pops one byte; serial drains it in tx
    logic par_pop;
    logic ser_pop;
    assign par_pop = par_sel && bus_read_i && buf_valid;
    assign buf_pop = par_pop || ser_pop;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_read_data_o <= 8'h00;
            bus_read_valid_o <= 1'b0;
        end else begin
            bus_read_valid_o <= par_pop;
            bus_read_data_o <= par_pop ? buf_data : bus_read_data_o;
        end
    end

    // ************************************************************
    // poll recogniser
    // ************************************************************
    poll_t poll;
    poll_t next_poll;
    wire [7:0] g_ch = hex_char(serial_cfg_i.group_addr);
    wire [7:0] u_ch = hex_char(serial_cfg_i.user_addr);
    wire ser_sel = !par_sel;
    // a wrong byte sends the recogniser back to idle
    always_comb begin
        next_poll = poll;
        if (rx_valid_i && ser_sel) begin
            case (poll)
                P_IDLE: next_poll = (rx_byte_i == g_ch) ? P_G1 : P_IDLE;
                P_G1: next_poll = (rx_byte_i == g_ch) ? P_G2 : P_IDLE;
                P_G2: next_poll = (rx_byte_i == u_ch) ? P_U1 : P_IDLE;
                P_U1: next_poll = (rx_byte_i == u_ch) ? P_U2 : P_IDLE;
                P_U2: next_poll = (rx_byte_i == CH_P) ? P_P : P_IDLE;
                P_P: next_poll = (rx_byte_i == CH_O) ? P_O : P_IDLE;
                P_O: next_poll = P_IDLE;
                default: next_poll = P_IDLE;
            endcase
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            poll <= P_IDLE;
        end else begin
            poll <= next_poll;
        end
    end
    assign poll_hit = rx_valid_i && ser_sel && (poll == P_O) && (rx_byte_i == CH_ENQ);

    // ************************************************************
    // transmitter: block, check byte, gaps
    // ************************************************************
    tx_t tx;
    tx_t after_gap;
    logic [7:0] bcc;
    logic [7:0] tx_byte;
    logic [31:0] gap_cnt;
    wire tx_take = tx_valid_o && tx_ready_i;
    wire sending_etx = (tx == T_DATA) && (buf_data == CH_ETX);
    assign ser_pop = (tx == T_DATA) && tx_ready_i && buf_valid;
    assign tx_valid_o = (tx == T_DATA) ? buf_valid : (tx == T_BCC || tx == T_EOT);
    assign tx_byte_o = (tx == T_DATA) ? buf_data : tx_byte;
    wire bcc_clear = ser_pop && (buf_data == CH_STX);
    wire [7:0] next_bcc = bcc_clear ? 8'h00 : (ser_pop ? bcc ^ buf_data : bcc);
    wire gap_on = serial_cfg_i.char_delay;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bcc <= 8'h00;
        end else begin
            bcc <= next_bcc;
        end
    end
    assign block_check_character_o = bcc;
    // gap sits between any two sent bytes when enabled
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx <= T_IDLE;
            after_gap <= T_IDLE;
            tx_byte <= 8'h00;
            gap_cnt <= '0;
        end else begin
            case (tx)
                T_IDLE: begin
                    if (poll_hit) begin
                        tx <= buf_valid ? T_DATA : T_EOT;
                        tx_byte <= CH_EOT;
                    end
                end
                T_DATA: begin
                    if (tx_take) begin
                        after_gap <= T_DATA;
                        if (sending_etx && serial_cfg_i.block_check) begin
                            after_gap <= T_BCC;
                            tx_byte <= next_bcc;
                        end else if (sending_etx) begin
                            after_gap <= T_IDLE;
                        end
                        tx <= gap_on ? T_GAP : ((sending_etx && serial_cfg_i.block_check)
                            ? T_BCC : (sending_etx ? T_IDLE : T_DATA));
                        gap_cnt <= 32'(GAP_CYCLES);
                    end else if (!buf_valid) begin
                        tx <= T_IDLE;
                    end
                end
                T_BCC, T_EOT: begin
                    if (tx_ready_i) begin
                        after_gap <= T_IDLE;
                        tx <= gap_on ? T_GAP : T_IDLE;
                        gap_cnt <= 32'(GAP_CYCLES);
                    end
                end
                T_GAP: begin
                    gap_cnt <= gap_cnt - 32'd1;
                    if (gap_cnt <= 32'd1) begin
                        tx <= after_gap;
                    end
                end
                default: tx <= T_IDLE;
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    keys_locked_a: assert property (remote |-> panel_keys_o == 8'h00)
        else $error("panel keys pass while remote");
    enter_remote_a: assert property (go_remote && !go_local |=> remote)
        else $error("addressed command did not enter remote");
    gtl_local_a: assert property (go_to_local_i && !local_lockout_i |=> !remote && !lockout)
        else $error("go-to-local left device remote");
    lockout_key_a: assert property (lockout && !go_to_local_i && remote |=> remote)
        else $error("key left remote under lockout");
    parallel_sel_a: assert property (bus_addr_match_o |-> iface_sel_i == IF_PARALLEL)
        else $error("match without parallel selection");
    addr_range_a: assert property (bus_addr <= BUS_ADDR_MAX)
        else $error("bus address out of range");
    addr_update_a: assert property (bus_addr_we_i && addr_ok |=> bus_addr == $past(bus_addr_wdata_i))
        else $error("bus address not updated");
    accept_remote_a: assert property (cmd_accept_o |-> remote)
        else $error("command accepted in local state");
    empty_eot_a: assert property (poll_hit && tx == T_IDLE && !buf_valid |=> tx_byte_o == CH_EOT && tx_valid_o)
        else $error("empty poll did not answer EOT");
    bcc_clear_a: assert property (bcc_clear |=> bcc == 8'h00)
        else $error("check byte not cleared on start of text");
    duplex_only_a: assert property (half_duplex_o |-> rs485_o)
        else $error("half duplex outside RS485");

    cover_poll_c: cover property (poll_hit);
    cover_lockout_c: cover property (lockout ##1 go_to_local_i);
    cover_bcc_c: cover property (tx == T_BCC && tx_ready_i);
    cover_gap_c: cover property (tx == T_GAP);
endmodule : remote_front
`default_nettype wire

/* bench/host_ctrl_model.sv */
// Purpose: system controller stand-in on the serial side
// Assumes: byte-level link, bit-level uart lives elsewhere
// Notes: slow mode drops ready at random
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
    input wire logic clock_i,
    input wire logic slow_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_byte_o,
    output logic rx_valid_o
);
    import remote_front_pkg::*;
    // ************************************************************
    // receive side
    // ************************************************************
    logic [7:0] got_q[$];
    int got_t[$];
    int cyc = 0;
    logic ready = 1'b0;
    logic [15:0] lfsr = 16'hACE1;
    assign tx_ready_o = ready;
    // take a byte where valid and ready meet
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13]};
        if (tx_valid_i && ready) begin
            got_q.push_back(tx_byte_i);
            got_t.push_back(cyc);
        end
        ready <= !slow_i || lfsr[0];
    end
    // ************************************************************
    // poll sequence
    // ************************************************************
    function automatic logic [7:0] digit(input logic [3:0] d);
        return (d < 4'hA) ? 8'(8'h30 + d) : 8'(8'h57 + d);
    endfunction : digit
    // between strobes the line shows the inverse byte
    task automatic poll(input logic [3:0] g, input logic [3:0] u);
        logic [7:0] seq [7];
        seq = '{digit(g), digit(g), digit(u), digit(u), CH_P, CH_O, CH_ENQ};
        foreach (seq[i]) begin
            @(posedge clock_i);
            rx_byte_o <= seq[i];
            rx_valid_o <= 1'b1;
            @(posedge clock_i);
            rx_byte_o <= ~seq[i];
            rx_valid_o <= 1'b0;
        end
    endtask : poll
    // idle line at time zero
    initial begin
        rx_byte_o = 8'h00;
        rx_valid_o = 1'b0;
    end
endmodule : host_ctrl_model
`default_nettype wire

/* bench/remote_front_tb_top.sv */
// Purpose: self-checking bench for the remote-control front end
// Assumes: byte gap shortened to 4 cycles
// Notes: expectations come from queues kept beside the design
`timescale 1ns/1ps
`default_nettype none
module remote_front_tb_top;
    import remote_front_pkg::*;
    localparam int GAP = 4;
    logic clock_i;
    logic rst_n_i = 1'b0;
    iface_t iface = IF_RS232;
    serial_cfg_t cfg = '0;
    logic addr_cmd = 1'b0, go_local = 1'b0, lock_cmd = 1'b0, from_par = 1'b1, rtl_key = 1'b0;
    logic addr_we = 1'b0, ans_valid = 1'b0, bus_read = 1'b0, slow = 1'b0;
    logic [7:0] keys = 8'h00, ans_byte = 8'h00, x;
    logic [4:0] addr_wdata = 5'h00, talk_addr = 5'h00, exp_addr;
    logic [7:0] rx_byte, tx_byte, rd_data, keys_out, bcc;
    logic rx_valid, tx_valid, tx_ready, rd_valid, addr_match, ans_ready;
    logic remote, lockout, key_local, cmd_accept, rs485, half_duplex;
    logic [4:0] bus_addr;
    logic [4:0] wr[5] = '{5'h1E, 5'h1F, 5'h00, 5'h1F, 5'h11};
    logic [31:0] seed = 32'd66;
    logic [7:0] exp_q[$];
    logic [7:0] blk[$];
    int error_cnt = 0;
    int checked = 0;
    // ************************************************************
    // design and far side
    // ************************************************************
    remote_front #(.GAP_CYCLES(GAP), .FIFO_DEPTH(8)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .iface_sel_i(iface),
        .addressed_cmd_i(addr_cmd), .go_to_local_i(go_local), .local_lockout_i(lock_cmd),
        .bus_cmd_from_parallel_i(from_par), .panel_keys_i(keys), .return_to_local_key_i(rtl_key),
        .bus_addr_wdata_i(addr_wdata), .bus_addr_we_i(addr_we), .bus_talk_addr_i(talk_addr),
        .bus_addr_match_o(addr_match), .bus_addr_o(bus_addr), .serial_cfg_i(cfg),
        .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .answer_byte_i(ans_byte),
        .answer_valid_i(ans_valid), .answer_ready_o(ans_ready), .tx_byte_o(tx_byte),
        .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .bus_read_i(bus_read),
        .bus_read_data_o(rd_data), .bus_read_valid_o(rd_valid), .remote_o(remote),
        .lockout_o(lockout), .key_shows_local_o(key_local), .panel_keys_o(keys_out),
        .cmd_accept_o(cmd_accept), .rs485_o(rs485), .half_duplex_o(half_duplex),
        .block_check_character_o(bcc));
    host_ctrl_model host (.clock_i(clock_i), .slow_i(slow), .tx_byte_i(tx_byte),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid));
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // one-cycle pulses, then let the state settle
    task automatic cmd(input logic a, input logic g, input logic l);
        @(posedge clock_i);
        addr_cmd <= a;
        go_local <= g;
        lock_cmd <= l;
        @(posedge clock_i);
        addr_cmd <= 1'b0;
        go_local <= 1'b0;
        lock_cmd <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask : cmd
    // two sync flops and an edge detect: hold well past three cycles
    task automatic key_press();
        @(posedge clock_i);
        rtl_key <= 1'b1;
        repeat (6) @(posedge clock_i);
        rtl_key <= 1'b0;
        repeat (4) @(posedge clock_i);
        #1;
    endtask : key_press
    // expect a byte only if ready stands at the taking edge
    task automatic push(input logic [7:0] b);
        @(posedge clock_i);
        ans_byte <= b;
        ans_valid <= 1'b1;
        #1;
        if (ans_ready === 1'b1) exp_q.push_back(b);
    endtask : push
    task automatic rd(input logic want);
        @(posedge clock_i);
        bus_read <= 1'b1;
        @(posedge clock_i);
        bus_read <= 1'b0;
        #1;
        check("read valid", rd_valid, want);
        if (want) check("read data", rd_data, exp_q.pop_front());
    endtask : rd
    task automatic wait_bytes(input int n);
        for (int i = 0; i < 3000 && host.got_q.size() < n; i++) @(posedge clock_i);
        if (host.got_q.size() < n) begin
            error_cnt++;
            tally_and_finish();
        end
        repeat (20) @(posedge clock_i);
    endtask : wait_bytes
    // free-running core clock
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1;
        check("preset address", bus_addr, 5'h09);
        check("rs485 flag", rs485, 1'b0);
        check("half duplex flag", half_duplex, 1'b0);
        exp_addr = 5'h09;
        wr[4] = 5'(xs() % 31);
        @(posedge clock_i);
        iface <= IF_PARALLEL;
        // range ends, refused values, one random address
        for (int i = 0; i < 5; i++) begin
            @(posedge clock_i);
            addr_wdata <= wr[i];
            addr_we <= 1'b1;
            if (wr[i] <= 5'h1E) exp_addr = wr[i];
            talk_addr <= exp_addr;
            @(posedge clock_i);
            addr_we <= 1'b0;
            #1;
            check("bus address", bus_addr, exp_addr);
            check("address match", addr_match, 1'b1);
        end
        @(posedge clock_i);
        iface <= IF_RS232;
        #1;
        check("match off bus", addr_match, 1'b0);
        cmd(1'b1, 1'b0, 1'b0);
        check("remote from idle bus", remote, 1'b0);
        @(posedge clock_i);
        iface <= IF_PARALLEL;
        keys <= 8'(xs()) | 8'h01;
        cmd(1'b1, 1'b0, 1'b0);
        check("remote", remote, 1'b1);
        check("key label", key_local, 1'b1);
        check("accept", cmd_accept, 1'b1);
        check("keys blocked", keys_out, 8'h00);
        key_press();
        check("local by key", remote, 1'b0);
        check("keys pass", keys_out, keys);
        check("accept in local", cmd_accept, 1'b0);
        @(posedge clock_i);
        from_par <= 1'b0;
        iface <= IF_RS232;
        cmd(1'b1, 1'b0, 1'b0);
        cmd(1'b0, 1'b0, 1'b1);
        check("lockout", lockout, 1'b1);
        key_press();
        check("key under lockout", remote, 1'b1);
        cmd(1'b0, 1'b1, 1'b0);
        check("local by command", remote, 1'b0);
        // fill past full, one read off the bus, drain past empty
        for (int i = 0; i < 10; i++) push(8'(xs()));
        @(posedge clock_i);
        ans_valid <= 1'b0;
        iface <= IF_RS232;
        check("buffer depth", exp_q.size(), 8);
        rd(1'b0);
        @(posedge clock_i);
        iface <= IF_PARALLEL;
        repeat (9) rd(exp_q.size() > 0);
        @(posedge clock_i);
        iface <= IF_RS485;
        cfg.group_addr <= 4'(xs());
        cfg.user_addr <= 4'(xs());
        slow <= 1'b1;
        @(posedge clock_i);
        #1;
        check("rs485 flag", rs485, 1'b1);
        check("half duplex flag", half_duplex, 1'b1);
        // three blocks: check byte with gap, check byte alone, plain block
        for (int p = 0; p < 3; p++) begin
            @(posedge clock_i);
            cfg.block_check <= (p < 2);
            cfg.char_delay <= (p == 0);
            blk = '{CH_STX, 8'h41 + 8'(xs() % 26), 8'h41 + 8'(xs() % 26), CH_ETX};
            x = blk[1] ^ blk[2] ^ blk[3];
            foreach (blk[i]) push(blk[i]);
            @(posedge clock_i);
            ans_valid <= 1'b0;
            exp_q.delete();
            host.got_q.delete();
            host.got_t.delete();
            host.poll(cfg.group_addr, cfg.user_addr);
            if (p < 2) blk.push_back(x);
            wait_bytes(blk.size());
            check("sent count", host.got_q.size(), blk.size());
            foreach (blk[i]) check("sent byte", host.got_q[i], blk[i]);
            if (p < 2) check("check register", bcc, x);
            if (p == 0) for (int i = 1; i < 5; i++) check("byte gap", host.got_t[i] - host.got_t[i - 1] > GAP, 1);
        end
        host.got_q.delete();
        host.poll(cfg.group_addr, cfg.user_addr + 4'h1);
        repeat (40) @(posedge clock_i);
        check("foreign poll", host.got_q.size(), 0);
        host.poll(cfg.group_addr, cfg.user_addr);
        wait_bytes(1);
        check("empty poll answer", host.got_q[0], CH_EOT);
        tally_and_finish();
    end
endmodule : remote_front_tb_top
`default_nettype wire
